// File: src/gmec_defines.vh
// register offsets, field positions, reset values and timing for the event config bank
`ifndef GMEC_DEFINES_VH
`define GMEC_DEFINES_VH
`define GMEC_CMD_INTR 8'h00
`define GMEC_CMD_MASK 8'h01
`define GMEC_CMD_PWREV 8'h02
`define GMEC_CMD_DISCEV 8'h04
`define GMEC_CMD_PRIO1 8'h15
`define GMEC_CMD_CFG 8'h17
`define GMEC_CMD_PRIO3A 8'h27
`define GMEC_CMD_PRIO3B 8'h28
`define GMEC_CFG_GATE 7
`define GMEC_CFG_WIDE 5
`define GMEC_CFG_PRIOW 4
`define GMEC_CFG_CLSCHG 3
`define GMEC_CFG_DETCHG 2
`define GMEC_CFG_RESET 8'h80
`define GMEC_CFG_WMASK 8'hBC
`define GMEC_INT_PEC 0
`define GMEC_INT_PGC 1
`define GMEC_INT_DET 2
`define GMEC_INT_CLS 3
`define GMEC_INT_SUPPLY 7
`define GMEC_IDLE_US 200
`define GMEC_CLK_MHZ 100
`define GMEC_IDLE_CYCLES (`GMEC_IDLE_US * `GMEC_CLK_MHZ)
`endif

// File: src/gmec_chan_event.v
// one channel's detect and class event generator with change-only filtering
`timescale 1ns/1ps
module gmec_chan_event #(
    parameter RESW = 4
) (
    input wire clk,
    input wire rst_n,
    input wire detDone,
    input wire [RESW-1:0] detResult,
    input wire clsDone,
    input wire [RESW-1:0] clsResult,
    input wire detectChangeOnlyEnable,
    input wire classChangeOnlyEnable,
    output wire detEvent,
    output wire clsEvent
);
    reg [RESW-1:0] lastDet;
    reg [RESW-1:0] lastCls;

    // enables are sampled at the completion pulse itself, so a change applies in the same cycle
    assign detEvent = detDone & (~detectChangeOnlyEnable | (detResult != lastDet));
    assign clsEvent = clsDone & (~classChangeOnlyEnable | (clsResult != lastCls));

    always @(posedge clk) begin
        if (!rst_n) begin
            lastDet <= {RESW{1'b0}};
            lastCls <= {RESW{1'b0}};
        end else begin
            if (detDone) begin
                lastDet <= detResult;
            end
            if (clsDone) begin
                lastCls <= clsResult;
            end
        end
    end
endmodule // gmec_chan_event

// File: src/gmec_general_event_config.v
// eight-channel event configuration bank with 8-bit and 16-bit register access
// What this block does
// - with the priority width bit clear, each port uses a one-bit priority and fast-shutdown enable from command 15h.
// - with class-change-only set, a class event flag rises only when the class result differs from the last one.
// - with class-change-only clear, a class event flag rises after every completed classification.
// - detect-change-only set flags only changed detection results, and clear flags every detection.
// - both change-only enables are read/write and reset to zero.
// - 16-bit access follows the wide-access bit of the channel 1-4 group alone.
// - in 8-bit mode each four-channel group has its own interrupt register (00h) and mask (01h).
// - in 8-bit mode the supply event shows identically in both groups' interrupt registers.
// - with the priority width bit set, each port uses a three-bit priority from commands 27h and 28h.
// - wide access answers 16-bit transfers at one address, otherwise two 8-bit devices at two addresses.
`timescale 1ns/1ps
`include "gmec_defines.vh"
module gmec_general_event_config #(
    parameter RESW = 4,
    parameter IDLE_CYCLES = `GMEC_IDLE_CYCLES
) (
    input wire clk,
    input wire rst_n,
    input wire regWrite,
    input wire regRead,
    input wire devSel,
    input wire [7:0] cmd,
    input wire [15:0] wrData,
    output reg [15:0] rdData,
    output reg regAck,
    output wire wideAccess,
    input wire [7:0] detDone,
    input wire [8*RESW-1:0] detResult,
    input wire [7:0] clsDone,
    input wire [8*RESW-1:0] clsResult,
    input wire [7:0] powerEnableChange,
    input wire [7:0] powerGoodChange,
    input wire supplyEvent,
    input wire fastShutdownSerialInput,
    output reg fastShutdownIdleOk,
    output reg [23:0] portPriority,
    output reg [7:0] portFastShutdownEn,
    output reg multiBitPriority,
    output reg intRequest
);
    reg [7:0] cfg [0:1];
    reg [7:0] mask [0:1];
    reg [7:0] pwrEv [0:1];
    reg [7:0] discEv [0:1];
    reg [7:0] prio1 [0:1];
    reg [7:0] prio3a [0:1];
    reg [7:0] prio3b [0:1];
    reg supplyFlag;
    reg ossMeta;
    reg ossSync;
    reg [31:0] idleCount;
    wire [7:0] detEvent;
    wire [7:0] clsEvent;
    wire [1:0] grpWr;
    wire [1:0] grpRd;
    wire [7:0] wrByte [0:1];
    integer g;
    integer c;

    function [7:0] intrByte;
        input [7:0] pe;
        input [7:0] de;
        input sup;
        begin
            intrByte = 8'h00;
            intrByte[`GMEC_INT_PEC] = |pe[3:0];
            intrByte[`GMEC_INT_PGC] = |pe[7:4];
            intrByte[`GMEC_INT_DET] = |de[3:0];
            intrByte[`GMEC_INT_CLS] = |de[7:4];
            intrByte[`GMEC_INT_SUPPLY] = sup;
        end
    endfunction

    function [7:0] readByte;
        input grp;
        input [7:0] code;
        begin
            if (code == `GMEC_CMD_INTR) begin
                readByte = intrByte(pwrEv[grp], discEv[grp], supplyFlag);
            end else if (code == `GMEC_CMD_MASK) begin
                readByte = mask[grp];
            end else if (code == `GMEC_CMD_PWREV) begin
                readByte = pwrEv[grp];
            end else if (code == `GMEC_CMD_DISCEV) begin
                readByte = discEv[grp];
            end else if (code == `GMEC_CMD_PRIO1) begin
                readByte = prio1[grp];
            end else if (code == `GMEC_CMD_CFG) begin
                readByte = cfg[grp];
            end else if (code == `GMEC_CMD_PRIO3A) begin
                readByte = prio3a[grp];
            end else if (code == `GMEC_CMD_PRIO3B) begin
                readByte = prio3b[grp];
            end else begin
                readByte = 8'h00;
            end
        end
    endfunction

    // only the channel 1-4 group's bit selects wide access
    assign wideAccess = cfg[0][`GMEC_CFG_WIDE];
    // wide mode: one address carries both groups; narrow mode: address bit picks the group
    assign grpWr[0] = regWrite & ~devSel;
    assign grpWr[1] = regWrite & (wideAccess ? ~devSel : devSel);
    assign grpRd[0] = regRead & ~devSel;
    assign grpRd[1] = regRead & (wideAccess ? ~devSel : devSel);
    assign wrByte[0] = wrData[7:0];
    assign wrByte[1] = wideAccess ? wrData[15:8] : wrData[7:0];

    genvar ch;
    generate
        for (ch = 0; ch < 8; ch = ch + 1) begin : gChan
            gmec_chan_event #(
                .RESW(RESW)
            ) uEvent (
                .clk(clk),
                .rst_n(rst_n),
                .detDone(detDone[ch]),
                .detResult(detResult[ch*RESW +: RESW]),
                .clsDone(clsDone[ch]),
                .clsResult(clsResult[ch*RESW +: RESW]),
                .detectChangeOnlyEnable(cfg[ch/4][`GMEC_CFG_DETCHG]),
                .classChangeOnlyEnable(cfg[ch/4][`GMEC_CFG_CLSCHG]),
                .detEvent(detEvent[ch]),
                .clsEvent(clsEvent[ch])
            );
        end
    endgenerate

    // register file and sticky event flags; a set in the clearing cycle wins
    always @(posedge clk) begin
        if (!rst_n) begin
            for (g = 0; g < 2; g = g + 1) begin
                cfg[g] <= `GMEC_CFG_RESET;
                mask[g] <= 8'h00;
                pwrEv[g] <= 8'h00;
                discEv[g] <= 8'h00;
                prio1[g] <= 8'h00;
                prio3a[g] <= 8'h00;
                prio3b[g] <= 8'h00;
            end
            supplyFlag <= 1'b0;
        end else begin
            for (g = 0; g < 2; g = g + 1) begin
                if (grpWr[g] && cmd == `GMEC_CMD_CFG) begin
                    cfg[g] <= wrByte[g] & `GMEC_CFG_WMASK;
                end
                if (grpWr[g] && cmd == `GMEC_CMD_MASK) begin
                    mask[g] <= wrByte[g];
                end
                if (grpWr[g] && cmd == `GMEC_CMD_PRIO1) begin
                    prio1[g] <= wrByte[g];
                end
                if (grpWr[g] && cmd == `GMEC_CMD_PRIO3A) begin
                    prio3a[g] <= wrByte[g];
                end
                if (grpWr[g] && cmd == `GMEC_CMD_PRIO3B) begin
                    prio3b[g] <= wrByte[g];
                end
                pwrEv[g] <= ((grpRd[g] && cmd == `GMEC_CMD_PWREV) ? 8'h00 : pwrEv[g])
                    | {powerGoodChange[g*4 +: 4], powerEnableChange[g*4 +: 4]};
                discEv[g] <= ((grpRd[g] && cmd == `GMEC_CMD_DISCEV) ? 8'h00 : discEv[g])
                    | {clsEvent[g*4 +: 4], detEvent[g*4 +: 4]};
            end
            // a refused upper-address read in wide mode must not clear the shared flag
            supplyFlag <= (((grpRd[0] | grpRd[1]) && cmd == `GMEC_CMD_INTR) ? 1'b0 : supplyFlag)
                | supplyEvent;
        end
    end

    // bus answer: one cycle after the request, nothing for the upper address in wide mode
    always @(posedge clk) begin
        if (!rst_n) begin
            rdData <= 16'h0000;
            regAck <= 1'b0;
        end else begin
            regAck <= grpWr[0] | grpWr[1] | grpRd[0] | grpRd[1];
            if (grpRd[0] | grpRd[1]) begin
                if (wideAccess) begin
                    rdData <= {readByte(1'b1, cmd), readByte(1'b0, cmd)};
                end else begin
                    rdData <= {8'h00, readByte(devSel, cmd)};
                end
            end
        end
    end

    // per-port priority and fast-shutdown selection from the active width's registers
    always @(posedge clk) begin
        if (!rst_n) begin
            portPriority <= 24'h00_0000;
            portFastShutdownEn <= 8'h00;
            multiBitPriority <= 1'b0;
        end else begin
            multiBitPriority <= cfg[0][`GMEC_CFG_PRIOW];
            for (c = 0; c < 8; c = c + 1) begin
                if (cfg[c/4][`GMEC_CFG_PRIOW]) begin
                    portPriority[c*3 +: 3] <= (c % 4 < 2)
                        ? prio3a[c/4][(c%2)*4 +: 3] : prio3b[c/4][(c%2)*4 +: 3];
                    portFastShutdownEn[c] <= (c % 4 < 2)
                        ? prio3a[c/4][(c%2)*4+3] : prio3b[c/4][(c%2)*4+3];
                end else begin
                    portPriority[c*3 +: 3] <= {2'b00, prio1[c/4][4 + c%4]};
                    portFastShutdownEn[c] <= prio1[c/4][c%4];
                end
            end
        end
    end

    // idle watch on the serial shutdown pin, so firmware can check before widening priority
    always @(posedge clk) begin
        if (!rst_n) begin
            ossMeta <= 1'b0;
            ossSync <= 1'b0;
            idleCount <= 32'h0000_0000;
            fastShutdownIdleOk <= 1'b0;
        end else begin
            ossMeta <= fastShutdownSerialInput;
            ossSync <= ossMeta;
            if (ossSync) begin
                idleCount <= 32'h0000_0000;
                fastShutdownIdleOk <= 1'b0;
            end else if (idleCount >= IDLE_CYCLES - 1) begin
                fastShutdownIdleOk <= 1'b1;
            end else begin
                idleCount <= idleCount + 32'h0000_0001;
            end
        end
    end

    // alert request: masked summary per group, gated by each group's gate bit
    always @(posedge clk) begin
        if (!rst_n) begin
            intRequest <= 1'b0;
        end else begin
            intRequest <= (|(intrByte(pwrEv[0], discEv[0], supplyFlag) & mask[0])
                & cfg[0][`GMEC_CFG_GATE])
                | (|(intrByte(pwrEv[1], discEv[1], supplyFlag) & mask[1])
                & cfg[1][`GMEC_CFG_GATE]);
        end
    end
endmodule // gmec_general_event_config

// File: sim/gmec_check_asserts.sv
// port-level assertions for the event configuration bank
`timescale 1ns/1ps
`include "gmec_defines.vh"
module gmec_check_asserts (
    input wire clk,
    input wire rst_n,
    input wire regWrite,
    input wire regRead,
    input wire devSel,
    input wire [7:0] cmd,
    input wire [15:0] wrData,
    input wire regAck,
    input wire wideAccess,
    input wire [23:0] portPriority,
    input wire [7:0] portFastShutdownEn,
    input wire multiBitPriority,
    input wire intRequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        (regWrite || regRead) && (!wideAccess || !devSel);
    endsequence
    sequence s_cfg_wr;
        regWrite && cmd == `GMEC_CMD_CFG;
    endsequence
    property p_ack_after_take;
        s_take |=> regAck;
    endproperty
    a_ack_after_take: assert property (p_ack_after_take) else $error("no ack after request");
    property p_refuse_hi;
        (regWrite || regRead) && wideAccess && devSel |=> !regAck;
    endproperty
    a_refuse_hi: assert property (p_refuse_hi) else $error("upper device answered in wide mode");
    property p_ack_cause;
        !(regWrite || regRead) |=> !regAck;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_wide_set;
        s_cfg_wr ##0 !devSel |=> wideAccess == $past(wrData[`GMEC_CFG_WIDE]);
    endproperty
    a_wide_set: assert property (p_wide_set) else $error("wide access not from lower group");
    property p_wide_upper;
        s_cfg_wr ##0 devSel && !wideAccess |=> $stable(wideAccess);
    endproperty
    a_wide_upper: assert property (p_wide_upper) else $error("upper group changed access width");
    property p_prio_sel;
        s_cfg_wr ##0 !devSel |=> ##1 multiBitPriority == $past(wrData[`GMEC_CFG_PRIOW], 2);
    endproperty
    a_prio_sel: assert property (p_prio_sel) else $error("priority width not taken");
    // the width in force when the enables were loaded is the one seen a cycle later
    property p_fse_narrow;
        regWrite && cmd == `GMEC_CMD_PRIO1 && !devSel && !wideAccess |=> ##1
            multiBitPriority || portFastShutdownEn[3:0] == $past(wrData[3:0], 2);
    endproperty
    a_fse_narrow: assert property (p_fse_narrow) else $error("fast shutdown enables wrong");
    property p_reset_quiet;
        disable iff (1'b0) !rst_n |=> !regAck && !intRequest && portPriority == 24'h00_0000;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
endmodule // gmec_check_asserts
bind gmec_general_event_config gmec_check_asserts i_gmec_check_asserts (.clk(clk), .rst_n(rst_n),
    .regWrite(regWrite), .regRead(regRead), .devSel(devSel), .cmd(cmd), .wrData(wrData),
    .regAck(regAck), .wideAccess(wideAccess), .portPriority(portPriority),
    .portFastShutdownEn(portFastShutdownEn), .multiBitPriority(multiBitPriority),
    .intRequest(intRequest));

// File: sim/gmec_host_model.sv
// register bus host model issuing decoded transactions
`timescale 1ns/1ps
module gmec_host_model (
    input wire clk,
    input wire regAck,
    input wire [15:0] rdData,
    output logic regWrite,
    output logic regRead,
    output logic devSel,
    output logic [7:0] cmd,
    output logic [15:0] wrData
);
    initial begin
        {regWrite, regRead, devSel, cmd, wrData} = '0;
    end
    task automatic xfer(input logic w, input logic dv, input logic [7:0] c,
        input logic [15:0] wd, output logic [15:0] rd, output logic ok);
        int i;
        ok = 0;
        rd = 16'h0000;
        @(posedge clk); #1;
        regWrite = w;
        regRead = !w;
        devSel = dv;
        cmd = c;
        wrData = wd;
        @(posedge clk); #1;
        regWrite = 0;
        regRead = 0;
        // released qualifiers must not keep the last value
        cmd = ~c;
        wrData = ~wd;
        for (i = 0; i < 4 && !ok; i++) begin
            if (regAck === 1'b1) begin
                ok = 1;
                rd = rdData;
            end else begin
                @(posedge clk); #1;
            end
        end
    endtask
endmodule // gmec_host_model

// File: sim/gmec_general_event_config_tb.sv
// self-checking bench for the event configuration bank
`timescale 1ns/1ps
`include "gmec_defines.vh"
module gmec_general_event_config_tb;
    logic clk, rst_n, regWrite, regRead, devSel, regAck, wideAccess, supplyEvent, fsIn;
    logic idleOk, multiBitPriority, intRequest, ok, k;
    logic [7:0] cmd, detDone, clsDone, portFastShutdownEn, c, e, pwrChg;
    logic [15:0] wrData, rdData, d;
    logic [31:0] detResult, clsResult;
    logic [23:0] portPriority;
    logic [3:0] r;
    logic [20:0] rows [7];
    int err_total = 0;
    int n_compared = 0;
    gmec_general_event_config #(.RESW(4), .IDLE_CYCLES(16)) i_gmec_general_event_config (
        .clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead), .devSel(devSel),
        .cmd(cmd), .wrData(wrData), .rdData(rdData), .regAck(regAck), .wideAccess(wideAccess),
        .detDone(detDone), .detResult(detResult), .clsDone(clsDone), .clsResult(clsResult),
        .powerEnableChange(pwrChg), .powerGoodChange(8'h00), .supplyEvent(supplyEvent),
        .fastShutdownSerialInput(fsIn), .fastShutdownIdleOk(idleOk),
        .portPriority(portPriority), .portFastShutdownEn(portFastShutdownEn),
        .multiBitPriority(multiBitPriority), .intRequest(intRequest));
    gmec_host_model i_gmec_host_model (.clk(clk), .regAck(regAck), .rdData(rdData),
        .regWrite(regWrite), .regRead(regRead), .devSel(devSel), .cmd(cmd), .wrData(wrData));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic dv, input logic [7:0] cc,
        input logic [15:0] wd, input logic expOk);
        i_gmec_host_model.xfer(w, dv, cc, wd, d, ok);
        if (ok !== expOk) begin
            err_total++;
            $display("unexpected at %0t: answer presence wrong", $time);
            close_out();
        end
    endtask
    task automatic evt(input logic isCls, input logic [3:0] res);
        @(posedge clk); #1;
        if (isCls) begin
            clsResult[3:0] = res;
            clsDone[0] = 1;
        end else begin
            detResult[3:0] = res;
            detDone[0] = 1;
        end
        @(posedge clk); #1;
        detDone = 8'h00;
        clsDone = 8'h00;
    endtask
    initial begin
        // rows: config byte, class select, result, expected event byte
        rows = '{{8'h80, 1'b0, 4'h3, 8'h01}, {8'h80, 1'b0, 4'h3, 8'h01},
            {8'h84, 1'b0, 4'h3, 8'h00}, {8'h84, 1'b0, 4'h5, 8'h01},
            {8'h88, 1'b1, 4'h2, 8'h10}, {8'h88, 1'b1, 4'h2, 8'h00},
            {8'h80, 1'b1, 4'h2, 8'h10}};
        rst_n = 0;
        fsIn = 0;
        supplyEvent = 0;
        pwrChg = 8'h00;
        detDone = 8'h00;
        clsDone = 8'h00;
        detResult = 32'h0000_0000;
        clsResult = 32'h0000_0000;
        repeat (8) @(posedge clk);
        #1 rst_n = 1;
        bus(0, 0, `GMEC_CMD_CFG, 16'h0000, 1);
        check(d, 16'h0080);
        bus(0, 1, `GMEC_CMD_CFG, 16'h0000, 1);
        check(d, 16'h0080);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            {c, k, r, e} = rows[i];
            bus(1, 0, `GMEC_CMD_CFG, {8'h00, c}, 1);
            evt(k, r);
            bus(0, 0, `GMEC_CMD_DISCEV, 16'h0000, 1);
            check(d, {8'h00, e});
        end
        $display("test change-only table done");
        bus(1, 0, `GMEC_CMD_CFG, 16'h0080, 1);
        evt(0, 4'h9);
        bus(1, 0, `GMEC_CMD_CFG, 16'h0084, 1);
        bus(0, 0, `GMEC_CMD_DISCEV, 16'h0000, 1);
        check(d, 16'h0001);
        bus(1, 0, `GMEC_CMD_MASK, 16'h0003, 1);
        bus(1, 1, `GMEC_CMD_MASK, 16'h000C, 1);
        bus(0, 0, `GMEC_CMD_MASK, 16'h0000, 1);
        check(d, 16'h0003);
        bus(0, 1, `GMEC_CMD_MASK, 16'h0000, 1);
        check(d, 16'h000C);
        // a power change on channel 5 shows only in the upper group's registers
        @(posedge clk);
        #1 pwrChg = 8'h10;
        @(posedge clk);
        #1 pwrChg = 8'h00;
        bus(0, 1, `GMEC_CMD_INTR, 16'h0000, 1);
        check(d, 16'h0001);
        bus(0, 0, `GMEC_CMD_INTR, 16'h0000, 1);
        check(d, 16'h0000);
        bus(0, 1, `GMEC_CMD_PWREV, 16'h0000, 1);
        check(d, 16'h0001);
        bus(0, 1, `GMEC_CMD_PWREV, 16'h0000, 1);
        check(d, 16'h0000);
        $display("test groups done");
        bus(1, 0, `GMEC_CMD_PRIO1, 16'h00F1, 1);
        @(posedge clk);
        #1 check({12'h000, portFastShutdownEn[3:0]}, 16'h0001);
        check({13'h0000, portPriority[2:0]}, 16'h0001);
        // one high bit on the serial shutdown input restarts the idle count
        fsIn = 1;
        @(posedge clk);
        #1 fsIn = 0;
        repeat (3) @(posedge clk);
        #1 check({15'h0000, idleOk}, 16'h0000);
        // serial shutdown input stays low well past the idle count before widening
        repeat (24) @(posedge clk);
        #1 check({15'h0000, idleOk}, 16'h0001);
        bus(1, 0, `GMEC_CMD_CFG, 16'h0090, 1);
        bus(1, 0, `GMEC_CMD_PRIO3A, 16'h008D, 1);
        repeat (2) @(posedge clk);
        check({15'h0000, multiBitPriority}, 16'h0001);
        check({13'h0000, portPriority[2:0]}, 16'h0005);
        check({14'h0000, portFastShutdownEn[1:0]}, 16'h0003);
        $display("test priority done");
        @(posedge clk); #1 supplyEvent = 1;
        @(posedge clk); #1 supplyEvent = 0;
        check({15'h0000, intRequest}, 16'h0000);
        bus(1, 1, `GMEC_CMD_MASK, 16'h0080, 1);
        @(posedge clk);
        #1 check({15'h0000, intRequest}, 16'h0001);
        // only the lower group's wide bit is written
        bus(1, 0, `GMEC_CMD_CFG, 16'h00A0, 1);
        check({15'h0000, wideAccess}, 16'h0001);
        bus(0, 0, `GMEC_CMD_INTR, 16'h0000, 1);
        check(d, 16'h8080);
        bus(0, 1, `GMEC_CMD_INTR, 16'h0000, 0);
        check({15'h0000, ok}, 16'h0000);
        check({15'h0000, intRequest}, 16'h0000);
        bus(1, 0, `GMEC_CMD_CFG, 16'h0080, 1);
        check({15'h0000, wideAccess}, 16'h0000);
        $display("test wide access done");
        @(posedge clk);
        #1 rst_n = 0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        bus(0, 1, `GMEC_CMD_CFG, 16'h0000, 1);
        check(d, 16'h0080);
        $display("test mid-run reset done");
        close_out();
    end
endmodule // gmec_general_event_config_tb
